// >>> core/tsa_pkg.sv
// Constants and carrier types for the temperature sensor register and alarm block.
// Assumes an external bit engine that turns SMBus frames into byte-level transactions.
package tsa_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_LOCAL_TEMP   = 8'h00;
	localparam logic [7:0] CMD_REMOTE_TEMP  = 8'h01;
	localparam logic [7:0] CMD_STATUS       = 8'h02;
	localparam logic [7:0] CMD_CONFIG       = 8'h03;
	localparam logic [7:0] CMD_RATE         = 8'h04;
	localparam logic [7:0] CMD_LOC_HI       = 8'h05;
	localparam logic [7:0] CMD_LOC_LO       = 8'h06;
	localparam logic [7:0] CMD_REM_HI       = 8'h07;
	localparam logic [7:0] CMD_REM_LO       = 8'h08;
	localparam logic [7:0] CMD_CONFIG_WR    = 8'h09;
	localparam logic [7:0] CMD_RATE_WR      = 8'h0A;
	localparam logic [7:0] CMD_LOC_HI_WR    = 8'h0B;
	localparam logic [7:0] CMD_LOC_LO_WR    = 8'h0C;
	localparam logic [7:0] CMD_REM_HI_WR    = 8'h0D;
	localparam logic [7:0] CMD_REM_LO_WR    = 8'h0E;
	localparam logic [7:0] CMD_ONE_SHOT     = 8'h0F;
	localparam logic [7:0] CMD_SOFT_RESET   = 8'hFC;
	localparam logic [7:0] CMD_MAKER        = 8'hFE;
	localparam logic [7:0] CMD_PART         = 8'hFF;

	// ----------------------------------------
	// Reset values, fields and identity
	// ----------------------------------------
	localparam logic [7:0] POR_ZERO         = 8'h00;
	localparam logic [7:0] POR_HIGH_LIMIT   = 8'h7F;
	localparam logic [7:0] POR_LOW_LIMIT    = 8'hC9;
	localparam logic [7:0] POR_RATE         = 8'h00;
	localparam int         CFG_MASK_BIT     = 7;
	localparam int         CFG_STOP_BIT     = 6;
	localparam logic [2:0] RATE_FASTEST     = 3'h7;
	localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0C;
	localparam logic [1:0] ADDR_SETTLE      = 2'h2;
	// Identity bytes: the values are arbitrary.
	localparam logic [7:0] MAKER_CODE_VAL   = 8'h5A;
	localparam logic [7:0] PART_CODE_VAL    = 8'h3C;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned FAST_PERIOD_MS     = 125;
	localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
	localparam int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_MS * (CLK_FREQ_HZ / 1000);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		TXN_SEND       = 3'h0,
		TXN_WRITE      = 3'h1,
		TXN_READ       = 3'h2,
		TXN_RECV       = 3'h3,
		TXN_ALERT_READ = 3'h4,
		TXN_ALERT_DONE = 3'h5
	} tsa_txn_kind_t;

	typedef enum logic [0:0] {
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} tsa_conv_t;

	typedef struct packed {
		tsa_txn_kind_t kind;
		logic [7:0]    cmd;
		logic [7:0]    data;
	} tsa_txn_t;

	typedef struct packed {
		logic [7:0] data;
		logic       present;
	} tsa_reply_t;

	typedef struct packed {
		logic [7:0] localTemp;
		logic [7:0] remoteTemp;
		logic       diodeOpen;
	} tsa_meas_t;

	// Alarm flags in status-byte order: bits 6 down to 2.
	typedef struct packed {
		logic localOverFlag;
		logic localUnderFlag;
		logic remoteOverFlag;
		logic remoteUnderFlag;
		logic openFlag;
	} tsa_flags_t;

endpackage

// >>> core/tsa_regs.sv
// Register, command pointer, conversion control and alarm latch of a two-channel temperature sensor.
// Assumes an SMBus bit engine on linkClk that hands over byte transactions, and an ADC on ref_clk.
`timescale 1ns/10ps

// ----------------------------------------
// Link-side handshake
// ----------------------------------------
module tsa_link (
	input  wire logic                linkClk,
	input  wire logic                resetn,
	input  wire logic                txnValid,
	input  tsa_pkg::tsa_txn_t        txn,
	output logic                     txnReady,
	output logic                     reqTgl,
	output tsa_pkg::tsa_txn_t        reqHeld,
	input  wire logic                coreAck,
	input  tsa_pkg::tsa_reply_t      coreReply,
	output logic                     replyValid,
	output tsa_pkg::tsa_reply_t      reply
);
	typedef struct packed {
		tsa_pkg::tsa_txn_t   req;
		logic                reqTgl;
		logic                ackSync0;
		logic                ackSync1;
		logic                ackSync2;
		logic                replyValid;
		tsa_pkg::tsa_reply_t reply;
	} tsa_link_state_t;

	tsa_link_state_t state_reg;
	tsa_link_state_t state_next;

	// A new request is only taken once the core has answered the previous one.
	assign txnReady   = (state_reg.reqTgl == state_reg.ackSync1);
	assign reqTgl     = state_reg.reqTgl;
	assign reqHeld    = state_reg.req;
	assign replyValid = state_reg.replyValid;
	assign reply      = state_reg.reply;

	always_comb begin
		state_next            = state_reg;
		state_next.replyValid = 1'b0;
		state_next.ackSync0   = coreAck;
		state_next.ackSync1   = state_reg.ackSync0;
		state_next.ackSync2   = state_reg.ackSync1;
		if (txnValid && txnReady) begin
			state_next.req    = txn;
			state_next.reqTgl = ~state_reg.reqTgl;
		end
		// The core reply is stable once its acknowledge toggle has been seen here.
		if (state_reg.ackSync1 != state_reg.ackSync2) begin
			state_next.replyValid = 1'b1;
			state_next.reply      = coreReply;
		end
	end

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule

// ----------------------------------------
// Core registers and conversion control
// ----------------------------------------
module tsa_regs #(
	parameter int unsigned FAST_CYCLES = tsa_pkg::FAST_PERIOD_CYCLES
) (
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	input  wire logic                linkClk,
	input  wire logic                txnValid,
	input  tsa_pkg::tsa_txn_t        txn,
	output logic                     txnReady,
	output logic                     replyValid,
	output tsa_pkg::tsa_reply_t      reply,
	input  wire logic [6:0]          addrPins,
	input  wire logic                hardware_standby_pin,
	output logic                     adcStart,
	input  wire logic                adcDone,
	input  tsa_pkg::tsa_meas_t       adcResult,
	output logic                     convBusy,
	output logic                     alertOut,
	output logic                     alertOeN
);
	typedef struct packed {
		logic [7:0]          cmdPtr;
		logic [7:0]          cfg;
		logic [7:0]          rate;
		logic [7:0]          locHi;
		logic [7:0]          locLo;
		logic [7:0]          remHi;
		logic [7:0]          remLo;
		logic [7:0]          locTemp;
		logic [7:0]          remTemp;
		tsa_pkg::tsa_flags_t flags;
		tsa_pkg::tsa_flags_t cond;
		logic                alert;
		logic [6:0]          addr;
		logic [1:0]          addrAge;
		logic                oneShotReq;
		logic                oneShotRun;
		logic                swReset;
		tsa_pkg::tsa_conv_t  conv;
		logic [31:0]         rateCnt;
		logic                adcStart;
		logic                stbySync0;
		logic                stbySync1;
		logic [6:0]          addrSync0;
		logic [6:0]          addrSync1;
		logic                reqSync0;
		logic                reqSync1;
		logic                reqSync2;
		logic                ackTgl;
		tsa_pkg::tsa_reply_t resp;
	} tsa_core_state_t;

	tsa_core_state_t     state_reg;
	tsa_core_state_t     state_next;
	logic                linkReqTgl;
	tsa_pkg::tsa_txn_t   linkReq;

	// Power-on values of all software-visible state; synchroniser and handshake state is kept.
	function automatic tsa_core_state_t porFields(input tsa_core_state_t s);
		tsa_core_state_t p;
		p            = s;
		p.cmdPtr     = tsa_pkg::POR_ZERO;
		p.cfg        = tsa_pkg::POR_ZERO;
		p.rate       = tsa_pkg::POR_RATE;
		p.locHi      = tsa_pkg::POR_HIGH_LIMIT;
		p.remHi      = tsa_pkg::POR_HIGH_LIMIT;
		p.locLo      = tsa_pkg::POR_LOW_LIMIT;
		p.remLo      = tsa_pkg::POR_LOW_LIMIT;
		p.locTemp    = tsa_pkg::POR_ZERO;
		p.remTemp    = tsa_pkg::POR_ZERO;
		p.flags      = '0;
		p.cond       = '0;
		p.alert      = 1'b0;
		p.addrAge    = '0;
		p.oneShotReq = 1'b0;
		p.swReset    = 1'b0;
		p.conv       = tsa_pkg::CONV_IDLE;
		p.rateCnt    = '0;
		p.adcStart   = 1'b0;
		return p;
	endfunction

	// Interval grows by a factor of two per rate step below the fastest setting.
	function automatic logic [31:0] intervalCycles(input logic [2:0] code);
		return 32'(FAST_CYCLES) << (tsa_pkg::RATE_FASTEST - code);
	endfunction

	function automatic logic [7:0] readByte(input tsa_core_state_t s, input logic [7:0] code);
		logic [7:0] v;
		v = tsa_pkg::POR_ZERO;
		case (code)
			tsa_pkg::CMD_LOCAL_TEMP:  v = s.locTemp;
			tsa_pkg::CMD_REMOTE_TEMP: v = s.remTemp;
			tsa_pkg::CMD_STATUS:      v = {s.conv == tsa_pkg::CONV_RUN, s.flags, 2'b00};
			tsa_pkg::CMD_CONFIG:      v = s.cfg;
			tsa_pkg::CMD_RATE:        v = s.rate;
			tsa_pkg::CMD_LOC_HI:      v = s.locHi;
			tsa_pkg::CMD_LOC_LO:      v = s.locLo;
			tsa_pkg::CMD_REM_HI:      v = s.remHi;
			tsa_pkg::CMD_REM_LO:      v = s.remLo;
			tsa_pkg::CMD_MAKER:       v = tsa_pkg::MAKER_CODE_VAL;
			tsa_pkg::CMD_PART:        v = tsa_pkg::PART_CODE_VAL;
			default:                  v = tsa_pkg::POR_ZERO;
		endcase
		return v;
	endfunction

	tsa_link link (
		.linkClk    (linkClk),
		.resetn     (resetn),
		.txnValid   (txnValid),
		.txn        (txn),
		.txnReady   (txnReady),
		.reqTgl     (linkReqTgl),
		.reqHeld    (linkReq),
		.coreAck    (state_reg.ackTgl),
		.coreReply  (state_reg.resp),
		.replyValid (replyValid),
		.reply      (reply)
	);

	assign adcStart = state_reg.adcStart;
	assign convBusy = (state_reg.conv == tsa_pkg::CONV_RUN);
	// The pin is only ever pulled low; the enable releases it when no alarm is pending.
	assign alertOut = 1'b0;
	assign alertOeN = ~state_reg.alert;

	always_comb begin
		logic                readNow;
		logic [7:0]          readCode;
		logic                clearFlags;
		logic                clearAlert;
		logic                hwStandby;
		tsa_pkg::tsa_flags_t newCond;
		readNow     = 1'b0;
		readCode    = state_reg.cmdPtr;
		clearFlags  = 1'b0;
		clearAlert  = 1'b0;
		hwStandby   = state_reg.stbySync1;
		newCond     = '0;
		state_next  = state_reg;
		state_next.adcStart  = 1'b0;
		state_next.stbySync0 = hardware_standby_pin;
		state_next.stbySync1 = state_reg.stbySync0;
		state_next.addrSync0 = addrPins;
		state_next.addrSync1 = state_reg.addrSync0;
		state_next.reqSync0  = linkReqTgl;
		state_next.reqSync1  = state_reg.reqSync0;
		state_next.reqSync2  = state_reg.reqSync1;
		// Address straps and the first conversion wait a few cycles after reset for the synchronisers to settle.
		if (state_reg.addrAge != 2'h3) begin
			state_next.addrAge = state_reg.addrAge + 2'h1;
		end
		if (state_reg.addrAge == tsa_pkg::ADDR_SETTLE) begin
			state_next.addr = state_reg.addrSync1;
		end

		// ----------------------------------------
		// Transactions from the link
		// ----------------------------------------
		if (state_reg.reqSync1 != state_reg.reqSync2) begin
			state_next.ackTgl       = state_reg.reqSync1;
			state_next.resp.present = 1'b0;
			case (linkReq.kind)
				tsa_pkg::TXN_SEND: begin
					if (linkReq.cmd == tsa_pkg::CMD_ONE_SHOT) begin
						state_next.oneShotReq = (state_reg.conv == tsa_pkg::CONV_IDLE);
					end else if (linkReq.cmd == tsa_pkg::CMD_SOFT_RESET) begin
						state_next.swReset = 1'b1;
					end else begin
						state_next.cmdPtr = linkReq.cmd;
					end
				end
				tsa_pkg::TXN_WRITE: begin
					state_next.cmdPtr = linkReq.cmd;
					case (linkReq.cmd)
						tsa_pkg::CMD_CONFIG_WR: state_next.cfg    = linkReq.data;
						tsa_pkg::CMD_RATE_WR:   state_next.rate   = linkReq.data;
						tsa_pkg::CMD_LOC_HI_WR: state_next.locHi  = linkReq.data;
						tsa_pkg::CMD_LOC_LO_WR: state_next.locLo  = linkReq.data;
						tsa_pkg::CMD_REM_HI_WR: state_next.remHi  = linkReq.data;
						tsa_pkg::CMD_REM_LO_WR: state_next.remLo  = linkReq.data;
						default:                state_next.cmdPtr = linkReq.cmd;
					endcase
				end
				tsa_pkg::TXN_READ: begin
					state_next.cmdPtr = linkReq.cmd;
					readNow           = 1'b1;
					readCode          = linkReq.cmd;
				end
				tsa_pkg::TXN_RECV:       readNow = 1'b1;
				tsa_pkg::TXN_ALERT_READ: begin
					state_next.resp.data    = {state_reg.addr, 1'b1};
					state_next.resp.present = state_reg.alert;
				end
				// Bit 0 of the data reports that the answer won arbitration and was acknowledged.
				tsa_pkg::TXN_ALERT_DONE: clearAlert = linkReq.data[0];
				default:                 state_next.resp.present = 1'b0;
			endcase
			if (readNow) begin
				state_next.resp.data    = readByte(state_reg, readCode);
				state_next.resp.present = 1'b1;
				clearFlags              = (readCode == tsa_pkg::CMD_STATUS);
			end
		end
		// A status read leaves the alarm latch alone.
		if (clearFlags) begin
			state_next.flags = state_reg.cond;
		end
		if (clearAlert) begin
			state_next.alert = 1'b0;
		end

		// ----------------------------------------
		// Conversion sequencing
		// ----------------------------------------
		if (state_reg.rateCnt != 32'h0) begin
			state_next.rateCnt = state_reg.rateCnt - 32'h1;
		end
		case (state_reg.conv)
			tsa_pkg::CONV_IDLE: begin
				if (!hwStandby && state_reg.addrAge >= tsa_pkg::ADDR_SETTLE && (state_reg.oneShotReq ||
						(!state_reg.cfg[tsa_pkg::CFG_STOP_BIT] && state_reg.rateCnt == 32'h0))) begin
					state_next.conv       = tsa_pkg::CONV_RUN;
					state_next.adcStart   = 1'b1;
					state_next.oneShotRun = state_reg.oneShotReq;
					state_next.rateCnt    = intervalCycles(state_reg.rate[2:0]);
				end
			end
			tsa_pkg::CONV_RUN: begin
				state_next.oneShotReq = 1'b0;
				if (hwStandby || (state_reg.cfg[tsa_pkg::CFG_STOP_BIT] && !state_reg.oneShotRun)) begin
					state_next.conv = tsa_pkg::CONV_IDLE;
				end else if (adcDone) begin
					state_next.conv    = tsa_pkg::CONV_IDLE;
					state_next.locTemp = adcResult.localTemp;
					state_next.remTemp = adcResult.remoteTemp;
					newCond.localOverFlag   = $signed(adcResult.localTemp) >= $signed(state_reg.locHi);
					newCond.localUnderFlag  = $signed(adcResult.localTemp) <= $signed(state_reg.locLo);
					newCond.remoteOverFlag  = $signed(adcResult.remoteTemp) >= $signed(state_reg.remHi);
					newCond.remoteUnderFlag = $signed(adcResult.remoteTemp) <= $signed(state_reg.remLo);
					newCond.openFlag        = adcResult.diodeOpen;
					state_next.cond  = newCond;
					state_next.flags = state_next.flags | newCond;
					if (newCond != '0 && !state_reg.cfg[tsa_pkg::CFG_MASK_BIT]) begin
						state_next.alert = 1'b1;
					end
				end
			end
			default: begin
				state_next.conv = tsa_pkg::CONV_IDLE;
			end
		endcase
		// Software reset restores every register and re-samples the address straps.
		if (state_reg.swReset) begin
			state_next = porFields(state_next);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= porFields('0);
		end else begin
			state_reg <= state_next;
		end
	end
endmodule

// >>> tb/tsa_adc_model.sv
// Converter model that answers adcStart with adcDone after a fixed conversion time.
// Assumes the register block drives adcStart and convBusy on ref_clk.
`timescale 1ns/10ps
module tsa_adc_model #(
	parameter int CONV_CYCLES = 20
) (
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic         adcStart,
	input  wire logic         convBusy,
	input  tsa_pkg::tsa_meas_t meas,
	output logic              adcDone,
	output tsa_pkg::tsa_meas_t adcResult
);
	int cnt;
	// The result is only valid with adcDone; at other times the inverse is shown.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			adcDone <= 1'b0;
			adcResult <= ~meas;
		end else begin
			adcDone <= 1'b0;
			adcResult <= ~meas;
			if (adcStart) begin
				cnt <= CONV_CYCLES;
			end else if (!convBusy) begin
				cnt <= 0;
			end else if (cnt == 1) begin
				cnt <= 0;
				adcDone <= 1'b1;
				adcResult <= meas;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// >>> tb/tsa_regs_monitor.sv
// Port-level checks on the register block.
// Assumes it is bound to tsa_regs and sees only its ports.
`timescale 1ns/10ps
module tsa_regs_monitor #(
	parameter int unsigned FAST_CYCLES = 200
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic linkClk,
	input wire logic txnValid,
	input wire logic txnReady,
	input wire logic replyValid,
	input wire logic adcStart,
	input wire logic adcDone,
	input wire logic convBusy,
	input wire logic alertOut,
	input wire logic alertOeN
);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_conv_end;
		adcDone && convBusy;
	endsequence
	sequence s_take;
		txnValid && txnReady;
	endsequence

	// ----------------------------------------
	// Core domain
	// ----------------------------------------
	chk_pin_drain_low: assert property (@(posedge ref_clk) disable iff (!resetn) alertOut == 1'b0)
		else $error("alarm data not low");
	chk_alarm_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(alertOeN) |-> $past(adcDone) && $past(convBusy)) else $error("alarm without conversion end");
	chk_busy_start: assert property (@(posedge ref_clk) disable iff (!resetn) $rose(convBusy) |-> adcStart)
		else $error("busy without start");
	chk_start_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) adcStart |=> !adcStart)
		else $error("start longer than one cycle");
	chk_conv_once: assert property (@(posedge ref_clk) disable iff (!resetn) s_conv_end |=> !convBusy)
		else $error("busy after conversion end");

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	chk_reply_bound: assert property (@(posedge linkClk) disable iff (!resetn) s_take |-> ##[2:40] replyValid)
		else $error("no answer to request");
	chk_ready_hold: assert property (@(posedge linkClk) disable iff (!resetn) s_take |=> !txnReady [*2])
		else $error("ready while request open");
	chk_reply_pulse: assert property (@(posedge linkClk) disable iff (!resetn) replyValid |=> !replyValid)
		else $error("answer longer than one cycle");
	chk_ready_return: assert property (@(posedge linkClk) disable iff (!resetn) $rose(txnReady) |=> replyValid)
		else $error("ready without answer");
endmodule

bind tsa_regs tsa_regs_monitor #(.FAST_CYCLES(FAST_CYCLES)) u_mon (.ref_clk(ref_clk), .resetn(resetn),
	.linkClk(linkClk), .txnValid(txnValid), .txnReady(txnReady), .replyValid(replyValid), .adcStart(adcStart),
	.adcDone(adcDone), .convBusy(convBusy), .alertOut(alertOut), .alertOeN(alertOeN));

// >>> tb/tsa_regs_tb.sv
// Self-checking bench for the register block: byte transactions on linkClk, converter model on ref_clk.
// Assumes the package and tsa_regs are compiled first.
`timescale 1ns/10ps
module tsa_regs_tb;
	logic ref_clk = 1'b0;
	logic linkClk = 1'b0;
	logic resetn = 1'b0;
	logic txnValid = 1'b0;
	tsa_pkg::tsa_txn_t txn = '0;
	logic txnReady, replyValid, adcStart, adcDone, convBusy, alertOut, alertOeN;
	tsa_pkg::tsa_reply_t reply, rep;
	tsa_pkg::tsa_meas_t meas = '{8'h19, 8'h10, 1'b0};
	tsa_pkg::tsa_meas_t adcResult;
	logic [6:0] addrPins = 7'h2A;
	logic hardware_standby_pin = 1'b1;
	int errors = 0, checks_done = 0, starts = 0, cycles = 0, s0;
	logic [7:0] porv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, tsa_pkg::POR_RATE, tsa_pkg::POR_HIGH_LIMIT,
		tsa_pkg::POR_LOW_LIMIT, tsa_pkg::POR_HIGH_LIMIT, tsa_pkg::POR_LOW_LIMIT};
	logic [7:0] wv [6] = '{8'h0F, 8'h07, 8'h1E, 8'h05, 8'h50, 8'hC0};

	always #2.5 ref_clk = ~ref_clk;
	always #6 linkClk = ~linkClk;

	tsa_regs #(.FAST_CYCLES(200)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .linkClk(linkClk), .txnValid(txnValid),
		.txn(txn), .txnReady(txnReady), .replyValid(replyValid), .reply(reply), .addrPins(addrPins),
		.hardware_standby_pin(hardware_standby_pin), .adcStart(adcStart), .adcDone(adcDone),
		.adcResult(adcResult), .convBusy(convBusy), .alertOut(alertOut), .alertOeN(alertOeN));
	tsa_adc_model u_adc (.ref_clk(ref_clk), .resetn(resetn), .adcStart(adcStart), .convBusy(convBusy),
		.meas(meas), .adcDone(adcDone), .adcResult(adcResult));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One request, held through its taking edge; the answer is read while it stands.
	task automatic xfer(input tsa_pkg::tsa_txn_kind_t k, input logic [7:0] c, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge linkClk);
		while (txnReady !== 1'b1) @(negedge linkClk);
		txnValid = 1'b1;
		txn = '{kind: k, cmd: c, data: d};
		@(negedge linkClk);
		txnValid = 1'b0;
		while (replyValid !== 1'b1 && n < 60) begin
			@(negedge linkClk);
			n++;
		end
		if (n >= 60) chk(8'h00, 8'h01, "answer timeout");
		rep = reply;
	endtask

	task automatic rdchk(input logic [7:0] c, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
		xfer(tsa_pkg::TXN_READ, c, 8'h00);
		chk(rep.data & m, exp, "read data");
		chk({7'h00, rep.present}, 8'h01, "read present");
	endtask

	task automatic wait_conv();
		int n;
		n = 0;
		@(negedge ref_clk);
		while (adcDone !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 3000) chk(8'h00, 8'h01, "no conversion");
		repeat (3) @(negedge ref_clk);
	endtask

	always @(negedge ref_clk) begin
		cycles++;
		if (adcStart === 1'b1) starts++;
		if (cycles == 50000) begin
			chk(8'h00, 8'h01, "run timeout");
			end_sim();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge ref_clk);
		resetn = 1'b1;
		xfer(tsa_pkg::TXN_RECV, 8'h00, 8'h00);
		chk(rep.data, 8'h00, "first receive");
		for (int i = 0; i < 9; i++) rdchk(8'(i), porv[i]);
		rdchk(tsa_pkg::CMD_MAKER, tsa_pkg::MAKER_CODE_VAL);
		rdchk(tsa_pkg::CMD_PART, tsa_pkg::PART_CODE_VAL);
		$display("Test reset values done");
		for (int i = 0; i < 6; i++) xfer(tsa_pkg::TXN_WRITE, 8'(9 + i), wv[i]);
		xfer(tsa_pkg::TXN_WRITE, tsa_pkg::CMD_LOC_HI, 8'h00);
		for (int i = 0; i < 6; i++) rdchk(8'(3 + i), wv[i]);
		$display("Test writes done");
		meas.localTemp = 8'h1E;
		@(negedge ref_clk);
		hardware_standby_pin = 1'b0;
		wait_conv();
		chk({7'h00, alertOeN}, 8'h00, "alarm on equal");
		rdchk(tsa_pkg::CMD_STATUS, 8'h40, 8'h7F);
		meas.localTemp = 8'h14;
		wait_conv();
		wait_conv();
		rdchk(tsa_pkg::CMD_LOCAL_TEMP, 8'h14);
		rdchk(tsa_pkg::CMD_STATUS, 8'h40, 8'h7F);
		rdchk(tsa_pkg::CMD_STATUS, 8'h00, 8'h7F);
		chk({7'h00, alertOeN}, 8'h00, "alarm after status read");
		xfer(tsa_pkg::TXN_ALERT_DONE, 8'h00, 8'h00);
		chk({7'h00, alertOeN}, 8'h00, "alarm after lost answer");
		xfer(tsa_pkg::TXN_ALERT_READ, 8'h00, 8'h00);
		chk(rep.data, {addrPins, 1'b1}, "alert answer");
		chk({7'h00, rep.present}, 8'h01, "alert present");
		xfer(tsa_pkg::TXN_ALERT_DONE, 8'h00, 8'h01);
		repeat (4) @(negedge ref_clk);
		chk({7'h00, alertOeN}, 8'h01, "alarm cleared");
		wait_conv();
		chk({7'h00, alertOeN}, 8'h01, "alarm stays clear");
		$display("Test alarm done");
		xfer(tsa_pkg::TXN_WRITE, tsa_pkg::CMD_CONFIG_WR, 8'h80);
		meas.localTemp = 8'h1E;
		wait_conv();
		wait_conv();
		chk({7'h00, alertOeN}, 8'h01, "masked alarm");
		rdchk(tsa_pkg::CMD_STATUS, 8'h40, 8'h7F);
		$display("Test mask done");
		xfer(tsa_pkg::TXN_WRITE, tsa_pkg::CMD_CONFIG_WR, 8'h40);
		s0 = starts;
		repeat (400) @(negedge ref_clk);
		chk(8'(starts - s0), 8'h00, "standby starts");
		chk({7'h00, convBusy}, 8'h00, "standby busy");
		xfer(tsa_pkg::TXN_SEND, tsa_pkg::CMD_ONE_SHOT, 8'h00);
		wait_conv();
		repeat (400) @(negedge ref_clk);
		chk(8'(starts - s0), 8'h01, "one-shot starts");
		$display("Test standby done");
		xfer(tsa_pkg::TXN_SEND, tsa_pkg::CMD_SOFT_RESET, 8'h00);
		repeat (10) @(negedge ref_clk);
		rdchk(tsa_pkg::CMD_LOC_HI, tsa_pkg::POR_HIGH_LIMIT);
		rdchk(tsa_pkg::CMD_CONFIG, 8'h00);
		$display("Test soft reset done");
		end_sim();
	end
endmodule
